// ### src/ptmc_pkg.sv
package ptmc_pkg;
	localparam int CNT_W = 8;
	localparam int PS_W = 5;
	localparam int MODE_W = 5;
	localparam int SRC_W = 3;
	localparam int NSRC = 8;
	localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
	localparam logic [CNT_W-1:0] PERIOD_RST = 8'hFF;
	localparam logic [PS_W-1:0] PS_RST = 5'h00;
	// Upper mode bits select the family
	localparam logic [1:0] FAM_FREE = 2'h0;
	localparam logic [1:0] FAM_ONESHOT = 2'h1;
	localparam logic [1:0] FAM_MONO = 2'h2;
	localparam logic [1:0] FAM_LEVEL = 2'h3;
	localparam logic [2:0] SUB_0 = 3'h0;
	localparam logic [2:0] SUB_1 = 3'h1;
	localparam logic [2:0] SUB_2 = 3'h2;
	localparam logic [2:0] SUB_3 = 3'h3;
	localparam logic [2:0] SUB_4 = 3'h4;
	localparam logic [2:0] SUB_5 = 3'h5;
	localparam logic [2:0] SUB_6 = 3'h6;
	localparam logic [2:0] SUB_7 = 3'h7;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} ptmc_state_e;
endpackage : ptmc_pkg

// ### src/ptmc_trig_if.sv
`timescale 1ns/100ps
interface ptmc_trig_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : ptmc_trig_if

// ### src/ptmc_trig_sel.sv
`timescale 1ns/100ps
module ptmc_trig_sel (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic freeze_i,
	input wire logic [ptmc_pkg::NSRC-1:0] src_i,
	input wire logic [ptmc_pkg::SRC_W-1:0] sel_i,
	ptmc_trig_if.src trig
);
	logic sel_val;
	logic held;
	logic prev;
	assign sel_val = src_i[sel_i]; // [R07]
	// Sample on the timer tick so edges are in timer time; freeze holds the old level
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			held <= 1'b0;
			prev <= 1'b0;
		end
		else if (tick_i && !freeze_i) // [R11]
		begin
			prev <= held;
			held <= sel_val;
		end
	end
	assign trig.level = held;
	assign trig.rise = held && !prev;
	assign trig.fall = !held && prev;
endmodule : ptmc_trig_sel

// ### src/ptmc_postscale.sv
`timescale 1ns/100ps
module ptmc_postscale (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic clear_i,
	input wire logic match_i,
	input wire logic [ptmc_pkg::PS_W-1:0] select_i,
	output logic pulse_o
);
	logic [ptmc_pkg::PS_W-1:0] ps_count;
	logic hit;
	// Select field n gives a 1:(n+1) ratio
	assign hit = match_i && (ps_count == select_i); // [R05]
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_i) // [R02]
			ps_count <= ptmc_pkg::PS_RST;
		else if (tick_i && hit)
			ps_count <= ptmc_pkg::PS_RST;
		else if (tick_i && match_i)
			ps_count <= ps_count + 5'h01; // [R06]
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_i)
			pulse_o <= 1'b0;
		else if (tick_i)
			pulse_o <= hit; // [R05]
	end
endmodule : ptmc_postscale

// ### src/ptmc_top.sv
// Operation
// [R01] One-shot: period match clears run bit, halts; needs run bit cycled to restart
// [R02] Postscaler cleared on every restart; nonzero postscale pointless in one-shot
// [R03] Monostable halts at match like one-shot but keeps run bit set
// [R04] Monostable: later trigger edge restarts halted timer without software
// [R05] Period pulse lasts one tick when postscaler count equals select field
// [R06] Postscaler counter advances on every count/period match
// [R07] Each timer has its own trigger source selector
// [R08] Mode comes from 5-bit mode field
// [R09] Trigger source spaces edges at least six ticks apart
// [R10] Trigger source holds levels at least three ticks
// [R11] Trigger activity ignored during debug freeze
// [R12] Mode 00/000: count while run bit set, pulse on match
// [R13] Codes 001/010: count only while trigger high/low and run set
// [R14] Codes 011/100/101: reset on any/rising/falling edge, stop by run bit
// [R15] Codes 110/111: hold reset while trigger low/high
// [R16] One-shot 000: run bit starts; ends on clear or after match
// [R17] One-shot 001/010/011: start on rising/falling/any edge, no reset
// [R18] One-shot 100/101 edge start+reset; 110/111 edge start, level reset
// [R19] Monostable 001/010: edge start, stop on clear or after match
// [R20] Level one-shot 110/111: level start, opposite level reset
// [R21] On match, signal postscaler and clear count next tick
// [R22] Edge-start modes need fresh edge after run bit re-set
// [R23] One-shot: tick after match clears run bit, count stops at zero
// [R24] Monostable: tick after match stops at zero, run bit kept
// [R25] Reserved codes hold count and produce no period pulse
`timescale 1ns/100ps
module ptmc_top (
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic TICK_I,
	input wire logic FREEZE_I,
	input wire logic RUN_SET_I,
	input wire logic RUN_CLR_I,
	input wire logic [ptmc_pkg::MODE_W-1:0] MODE_I,
	input wire logic [ptmc_pkg::PS_W-1:0] POSTSCALE_SELECT_I,
	input wire logic [ptmc_pkg::SRC_W-1:0] TRIGGER_SOURCE_SELECT_I,
	input wire logic [ptmc_pkg::NSRC-1:0] TRIGGER_SOURCES_I,
	input wire logic PERIOD_WR_I,
	input wire logic [ptmc_pkg::CNT_W-1:0] PERIOD_VALUE_I,
	input wire logic COUNT_WR_I,
	input wire logic [ptmc_pkg::CNT_W-1:0] COUNT_WR_DATA_I,
	input wire logic CONTROL_WR_I,
	output logic RUN_BIT_O,
	output logic [ptmc_pkg::CNT_W-1:0] COUNT_VALUE_O,
	output logic [ptmc_pkg::CNT_W-1:0] PERIOD_BUFFER_O,
	output logic PERIOD_PULSE_OUT_O,
	output logic RUNNING_O
);
	////////////////////////////////////////////////////////////////////////////
	ptmc_trig_if trig ();
	logic [1:0] fam;
	logic [2:0] sub;
	logic [ptmc_pkg::CNT_W-1:0] period_value;
	logic [ptmc_pkg::CNT_W-1:0] count_value;
	logic [ptmc_pkg::CNT_W-1:0] period_buffer;
	logic run_bit;
	logic run_prev;
	ptmc_pkg::ptmc_state_e state;
	logic match;
	logic reserved;
	logic one_shot;
	logic mono;
	logic edge_start;
	logic start_ev;
	logic hw_reset;
	logic gate_ok;
	logic counting;
	logic restart;
	logic ext_reset_ev;
	logic pulse;

	assign fam = MODE_I[4:3]; // [R08]
	assign sub = MODE_I[2:0];

	ptmc_trig_sel u_sel (
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.tick_i(TICK_I),
		.freeze_i(FREEZE_I),
		.src_i(TRIGGER_SOURCES_I),
		.sel_i(TRIGGER_SOURCE_SELECT_I),
		.trig(trig.src)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode
	always_comb
	begin
		reserved = 1'b0;
		one_shot = 1'b0;
		mono = 1'b0;
		edge_start = 1'b0;
		start_ev = 1'b0;
		hw_reset = 1'b0;
		gate_ok = 1'b1;
		unique case (fam)
			ptmc_pkg::FAM_FREE:
			begin
				unique case (sub)
					ptmc_pkg::SUB_0: gate_ok = 1'b1; // [R12]
					ptmc_pkg::SUB_1: gate_ok = trig.level; // [R13]
					ptmc_pkg::SUB_2: gate_ok = !trig.level; // [R13]
					ptmc_pkg::SUB_3: hw_reset = trig.rise || trig.fall; // [R14]
					ptmc_pkg::SUB_4: hw_reset = trig.rise; // [R14]
					ptmc_pkg::SUB_5: hw_reset = trig.fall; // [R14]
					ptmc_pkg::SUB_6: hw_reset = !trig.level; // [R15]
					ptmc_pkg::SUB_7: hw_reset = trig.level; // [R15]
				endcase
			end
			ptmc_pkg::FAM_ONESHOT:
			begin
				one_shot = 1'b1;
				edge_start = (sub != ptmc_pkg::SUB_0);
				unique case (sub)
					ptmc_pkg::SUB_0: start_ev = 1'b1; // [R16]
					ptmc_pkg::SUB_1: start_ev = trig.rise; // [R17]
					ptmc_pkg::SUB_2: start_ev = trig.fall; // [R17]
					ptmc_pkg::SUB_3: start_ev = trig.rise || trig.fall; // [R17]
					ptmc_pkg::SUB_4:
					begin
						start_ev = trig.rise; // [R18]
						hw_reset = trig.rise;
					end
					ptmc_pkg::SUB_5:
					begin
						start_ev = trig.fall; // [R18]
						hw_reset = trig.fall;
					end
					ptmc_pkg::SUB_6:
					begin
						start_ev = trig.rise; // [R18]
						hw_reset = !trig.level;
					end
					ptmc_pkg::SUB_7:
					begin
						start_ev = trig.fall; // [R18]
						hw_reset = trig.level;
					end
				endcase
			end
			ptmc_pkg::FAM_MONO:
			begin
				mono = 1'b1;
				edge_start = 1'b1;
				unique case (sub)
					ptmc_pkg::SUB_1: start_ev = trig.rise; // [R19]
					ptmc_pkg::SUB_2: start_ev = trig.fall; // [R19]
					ptmc_pkg::SUB_3: start_ev = trig.rise || trig.fall;
					default: reserved = 1'b1; // [R25]
				endcase
			end
			ptmc_pkg::FAM_LEVEL:
			begin
				one_shot = 1'b1;
				unique case (sub)
					ptmc_pkg::SUB_6:
					begin
						start_ev = trig.level; // [R20]
						hw_reset = !trig.level;
					end
					ptmc_pkg::SUB_7:
					begin
						start_ev = !trig.level; // [R20]
						hw_reset = trig.level;
					end
					default: reserved = 1'b1; // [R25]
				endcase
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Start/halt sequencing
	assign match = (count_value == period_buffer); // [R21]
	assign counting = run_bit && (state == ptmc_pkg::ST_RUN) && gate_ok && !hw_reset
		&& !reserved && !FREEZE_I;
	assign restart = TICK_I && !reserved && (state != ptmc_pkg::ST_RUN) && run_bit
		&& (state != ptmc_pkg::ST_DONE || mono) && start_ev;
	assign ext_reset_ev = TICK_I && run_bit && hw_reset && !reserved;

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			state <= ptmc_pkg::ST_IDLE;
		else if (!run_bit)
			state <= ptmc_pkg::ST_IDLE; // [R22]
		else if (fam == ptmc_pkg::FAM_FREE)
			state <= ptmc_pkg::ST_RUN;
		else if (TICK_I && counting && match && (one_shot || mono))
			state <= ptmc_pkg::ST_DONE; // [R03]
		else if (restart)
			state <= ptmc_pkg::ST_RUN; // [R04]
	end

	// Run bit: software set/clear; one-shot completion clears it
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			run_bit <= 1'b0;
		else if (RUN_SET_I)
			run_bit <= 1'b1;
		else if (RUN_CLR_I)
			run_bit <= 1'b0;
		else if (TICK_I && counting && match && one_shot)
			run_bit <= 1'b0; // [R01] [R23]
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			run_prev <= 1'b0;
		else
			run_prev <= run_bit;
	end

	////////////////////////////////////////////////////////////////////////////
	// Count and period buffer
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			count_value <= ptmc_pkg::COUNT_RST;
		else if (COUNT_WR_I)
			count_value <= COUNT_WR_DATA_I;
		else if (ext_reset_ev || restart)
			count_value <= ptmc_pkg::COUNT_RST; // [R14] [R15]
		else if (TICK_I && counting && match)
			count_value <= ptmc_pkg::COUNT_RST; // [R21] [R24]
		else if (TICK_I && counting)
			count_value <= count_value + 8'h01;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			period_value <= ptmc_pkg::PERIOD_RST;
		else if (PERIOD_WR_I)
			period_value <= PERIOD_VALUE_I;
	end

	// Buffer reloads keep a mid-period write from truncating the running period
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			period_buffer <= ptmc_pkg::PERIOD_RST;
		else if (COUNT_WR_I || CONTROL_WR_I || ext_reset_ev || (TICK_I && counting && match))
			period_buffer <= period_value;
	end

	////////////////////////////////////////////////////////////////////////////
	// Postscaler
	ptmc_postscale u_ps (
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.tick_i(TICK_I),
		.clear_i(COUNT_WR_I || CONTROL_WR_I || ext_reset_ev || restart
			|| (run_bit && !run_prev)), // [R02]
		.match_i(counting && match), // [R06]
		.select_i(POSTSCALE_SELECT_I),
		.pulse_o(pulse)
	);

	assign RUN_BIT_O = run_bit;
	assign COUNT_VALUE_O = count_value;
	assign PERIOD_BUFFER_O = period_buffer;
	assign PERIOD_PULSE_OUT_O = pulse;
	assign RUNNING_O = counting;
endmodule : ptmc_top

// ### test/ptmc_trig_src.sv
`timescale 1ns/100ps
// Far-side trigger source; holds back changes so edges stay spaced
module ptmc_trig_src (
	input wire logic clk_i,
	input wire logic tick_i,
	input wire logic [7:0] want_i,
	output logic [7:0] src_o
);
	logic [2:0] gap = 3'h6;
	initial src_o = 8'h00;
	always @(posedge clk_i)
	begin
		if (tick_i && gap != 3'h6)
			gap <= gap + 3'h1;
		else if (tick_i && want_i != src_o)
		begin
			src_o <= want_i;
			gap <= 3'h1;
		end
	end
endmodule : ptmc_trig_src

// ### test/ptmc_chk.sv
`timescale 1ns/100ps
module ptmc_chk (
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic TICK_I,
	input wire logic FREEZE_I,
	input wire logic RUN_SET_I,
	input wire logic RUN_CLR_I,
	input wire logic [4:0] MODE_I,
	input wire logic COUNT_WR_I,
	input wire logic RUN_BIT_O,
	input wire logic [7:0] COUNT_VALUE_O,
	input wire logic [7:0] PERIOD_BUFFER_O,
	input wire logic PERIOD_PULSE_OUT_O,
	input wire logic RUNNING_O
);
	logic m;
	// Match tick, writes excluded since they override the count
	assign m = TICK_I && RUNNING_O && !COUNT_WR_I && COUNT_VALUE_O == PERIOD_BUFFER_O;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	////////////////////////////////////////////////////////////////
	property p_match; m |=> COUNT_VALUE_O == 8'h00; endproperty
	a_match: assert property (p_match)
		else $error("count not cleared after match");
	property p_pulse; $rose(PERIOD_PULSE_OUT_O) |-> $past(m); endproperty
	a_pulse: assert property (p_pulse)
		else $error("pulse without match");
	property p_width; $fell(PERIOD_PULSE_OUT_O) |-> $past(TICK_I); endproperty
	a_width: assert property (p_width)
		else $error("pulse ended off a tick");
	property p_free;
		MODE_I == 5'h00 && TICK_I && RUNNING_O && !m && !COUNT_WR_I
		|=> COUNT_VALUE_O == $past(COUNT_VALUE_O) + 8'h01;
	endproperty
	a_free: assert property (p_free)
		else $error("free count did not advance");
	property p_run; !RUN_BIT_O && !RUN_SET_I |-> !RUNNING_O; endproperty
	a_run: assert property (p_run)
		else $error("counting with run bit clear");
	property p_frz; FREEZE_I |-> !RUNNING_O; endproperty
	a_frz: assert property (p_frz)
		else $error("counting in freeze");
	property p_os; m && MODE_I == 5'h08 && !RUN_SET_I |=> !RUN_BIT_O; endproperty
	a_os: assert property (p_os)
		else $error("one-shot kept run bit");
	property p_mono; m && MODE_I == 5'h11 && !RUN_CLR_I |=> RUN_BIT_O; endproperty
	a_mono: assert property (p_mono)
		else $error("monostable lost run bit");
	property p_rsv;
		MODE_I == 5'h10 && !COUNT_WR_I
		|=> $stable(COUNT_VALUE_O) && !$rose(PERIOD_PULSE_OUT_O);
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved mode active");
endmodule : ptmc_chk
bind ptmc_top ptmc_chk u_ptmc_chk (.*);

// ### test/ptmc_top_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ptmc_top_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tick = 1'b0, frz = 1'b0, rs = 1'b0, rc = 1'b0, pw = 1'b0, cw = 1'b0, kw = 1'b0;
	logic [4:0] mode = 5'h00, sel = 5'h00;
	logic [7:0] per = 8'h00, want = 8'h00, trg, cnt, pb, c;
	logic run, pulse;
	int n_fail = 0, n_compared = 0, cyc = 0, np;
	ptmc_top u_ptmc_top (.CLOCK_I(clk), .SYS_RST_I(rst), .TICK_I(tick), .FREEZE_I(frz),
		.RUN_SET_I(rs), .RUN_CLR_I(rc), .MODE_I(mode), .POSTSCALE_SELECT_I(sel),
		.TRIGGER_SOURCE_SELECT_I(3'h3), .TRIGGER_SOURCES_I(trg), .PERIOD_WR_I(pw),
		.PERIOD_VALUE_I(per), .COUNT_WR_I(kw), .COUNT_WR_DATA_I(8'h00), .CONTROL_WR_I(cw),
		.RUN_BIT_O(run), .COUNT_VALUE_O(cnt), .PERIOD_BUFFER_O(pb),
		.PERIOD_PULSE_OUT_O(pulse), .RUNNING_O());
	ptmc_trig_src u_ptmc_trig_src (.clk_i(clk), .tick_i(tick), .want_i(want), .src_o(trg));
	initial forever #10 clk = ~clk;
	// Tick every second clock so a pulse visibly spans two clocks
	always @(posedge clk)
	begin
		tick <= ~tick;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_fail++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic tk(int n);
		repeat (n) @(posedge clk iff tick);
		#1;
	endtask : tk
	task automatic pc(int n);
		np = 0;
		repeat (n)
		begin
			tk(1);
			np += (pulse === 1'b1);
		end
	endtask : pc
	// Run bit cleared first so edge-start modes arm afresh
	task automatic cfg(logic [4:0] m, logic [7:0] p, logic [4:0] s);
		@(posedge clk);
		mode <= m;
		per <= p;
		sel <= s;
		pw <= 1'b1;
		rc <= 1'b1;
		@(posedge clk);
		pw <= 1'b0;
		rc <= 1'b0;
		cw <= 1'b1;
		kw <= 1'b1;
		@(posedge clk);
		cw <= 1'b0;
		kw <= 1'b0;
		tk(2);
	endtask : cfg
	task automatic onoff(logic v);
		@(posedge clk);
		rs <= v;
		rc <= !v;
		@(posedge clk);
		rs <= 1'b0;
		rc <= 1'b0;
	endtask : onoff
	task automatic sync(string nm);
		for (int i = 0; i < 100 && pulse !== 1'b1; i++)
			tk(1);
		`CHK(nm, 1'b1, pulse)
	endtask : sync
	task automatic end_of_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		for (int s = 0; s <= 2; s += 2)
		begin
			cfg(5'h00, 8'h03, 5'(s));
			onoff(1'b1);
			sync("free sync");
			`CHK("clear", 8'h00, cnt)
			pc(48);
			`CHK("pulses", 48 / (4 * (s + 1)), np)
		end
		@(posedge clk) frz <= 1'b1;
		tk(2);
		c = cnt;
		tk(6);
		`CHK("frozen", c, cnt)
		@(posedge clk) frz <= 1'b0;
		$display("test free done");
		cfg(5'h10, 8'h03, 5'h00);
		onoff(1'b1);
		pc(20);
		`CHK("rsv count", 8'h00, cnt)
		`CHK("rsv pulse", 0, np)
		$display("test reserved done");
		@(posedge clk) want <= 8'h80;
		cfg(5'h01, 8'hC8, 5'h00);
		onoff(1'b1);
		tk(10);
		`CHK("gate low", 8'h00, cnt)
		@(posedge clk) want <= 8'h08;
		tk(16);
		`CHK("gate high", 1'b1, cnt > 8'h00)
		cfg(5'h04, 8'hC8, 5'h00);
		onoff(1'b1);
		tk(30);
		@(posedge clk) want <= 8'h00;
		tk(8);
		@(posedge clk) want <= 8'h08;
		tk(10);
		`CHK("edge reset", 1'b1, cnt < 8'h0C)
		$display("test hardware done");
		cfg(5'h08, 8'h05, 5'h00);
		onoff(1'b1);
		tk(12);
		`CHK("os run", 1'b0, run)
		tk(8);
		`CHK("os halt", 8'h00, cnt)
		@(posedge clk) want <= 8'h00;
		cfg(5'h11, 8'h05, 5'h00);
		onoff(1'b1);
		tk(8);
		`CHK("mono wait", 8'h00, cnt)
		@(posedge clk) want <= 8'h08;
		sync("mono start");
		tk(3);
		`CHK("mono run", 1'b1, run)
		`CHK("mono halt", 8'h00, cnt)
		@(posedge clk) want <= 8'h00;
		tk(8);
		@(posedge clk) want <= 8'h08;
		sync("mono again");
		$display("test one-shot done");
		end_of_test();
	end
endmodule : ptmc_top_tb
